// file: core/spicfg_consts.vh
// constants for the serial configuration register front end
`ifndef SPICFG_CONSTS_VH
`define SPICFG_CONSTS_VH
`define SPICFG_ADDR_W          15
`define SPICFG_ADDR_PRIMARY    15'h0000
`define SPICFG_ADDR_DEVCFG     15'h0002
`define SPICFG_ADDR_USRCFG     15'h0010
`define SPICFG_RST_PRIMARY     8'h30
`define SPICFG_RST_DEVCFG      8'h00
`define SPICFG_RST_USRCFG      8'h00
`define SPICFG_BIT_SOFTRST     7
`define SPICFG_BIT_ASCEND      5
`define SPICFG_BIT_OUTPIN      4
`define SPICFG_BIT_HOLD        0
`define SPICFG_MODE_NORMAL     2'h0
`define SPICFG_MODE_PDOWN      2'h3
`define SPICFG_SRST_NS         750
`define SPICFG_CLK_MHZ         50
`define SPICFG_SRST_CYC        ((`SPICFG_SRST_NS * `SPICFG_CLK_MHZ) / 1000)
`endif

// file: core/spicfg_regs.v
// serial configuration register bank front end, spi slave on sampled link pins
`timescale 1ns/1ns
`default_nettype none
// How it works
// - writing one to bit 7 of the primary register resets the whole chip
// - the soft reset bit clears itself on the first clock of the reset window
// - reset completes within 750 ns; host sends nothing meanwhile
// - streaming address increments when direction bit is one, else decrements
// - bit 4 of the primary register always reads one; read data leaves only on the serial out pin
// - primary register at address 0x0, resets to 0x30
// - device configuration register at address 0x2, resets to 0x00
// - mode field: zero normal, three power down, one and two reserved
// - address freeze bit holds the streaming address fixed
`include "spicfg_consts.vh"
module spicfg_regs (
    input  wire       mclk_i,       // system clock, 50 MHz
    input  wire       rstn_i,       // async reset, active low
    input  wire       sclk_i,       // spi serial clock
    input  wire       csn_i,        // spi chip select, active low
    input  wire       sdi_i,        // spi serial data in
    output reg        sdo_o,        // spi serial data out
    output reg        sdo_oe_o,     // sdo driven while reading
    output reg        chip_rst_o,   // full chip reset pulse window
    output reg        pdown_o,      // power-down mode selected
    output reg  [1:0] op_mode_o     // operating mode field
);
////////////////////////////////////////////////////////////////////////////////
// reset arrives at once but leaves through two flops, so all state wakes on one edge
reg        rst_s1;
reg        rst_s2;
always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        rst_s1 <= 1'b0;
        rst_s2 <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_s2 <= rst_s1;
    end
end
// internal reset copy, released in step with the clock
wire rstn = rst_s2;
////////////////////////////////////////////////////////////////////////////////
// three-stage sampling of the link pins; a change counts once stages 2 and 3 agree
// pin order: serial clock, select, data; reset values equal the idle pin levels,
// so no false clock edge or select is seen right after reset
localparam [2:0] PIN_IDLE = 3'h2;
wire [2:0]       pin_raw = {sdi_i, csn_i, sclk_i};
wire [2:0]       pin_f;
wire [1:0]       pin_new;
genvar           gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
        reg [2:0] stage;
        reg       filt;
        always @(posedge mclk_i or negedge rstn) begin
            if (!rstn) begin
                stage <= {3{PIN_IDLE[gi]}};
                filt  <= PIN_IDLE[gi];
            end else begin
                stage <= {stage[1:0], pin_raw[gi]};
                if (stage[1] == stage[2])
                    filt <= stage[2];
            end
        end
        assign pin_f[gi] = filt;
        // clock and select also need the level one edge early, to spot their edges
        if (gi < 2) begin : g_early
            assign pin_new[gi] = (stage[1] == stage[2]) ? stage[2] : pin_f[gi];
        end
    end
endgenerate
wire sclk_f    = pin_f[0];
wire sdi_f     = pin_f[2];
wire sclk_new  = pin_new[0];
wire csn_new   = pin_new[1];
// edges count only inside a frame
wire sclk_rise = sclk_new & ~sclk_f & ~csn_new;
wire sclk_fall = ~sclk_new & sclk_f & ~csn_new;
////////////////////////////////////////////////////////////////////////////////
// frame: 1 r/w bit, 15 address bits, then data bytes
// a write commits on the eighth rising edge of its byte, so partial bytes are dropped
reg  [7:0]                  reg_primary;
reg  [7:0]                  reg_devcfg;
reg  [7:0]                  reg_usrcfg;
reg  [`SPICFG_ADDR_W-1:0]   addr;
reg  [4:0]                  bitcnt;
reg                         hdr_done;
reg                         rd;
reg  [7:0]                  shreg;
reg  [7:0]                  txreg;
reg  [9:0]                  srst_cnt;
reg                         srst_busy;
reg  [7:0]                  rdata;
// load value makes the counter reach zero on the last cycle of the window
localparam [31:0]           SRST_LOAD = `SPICFG_SRST_CYC - 1;
wire                        ascend = reg_primary[`SPICFG_BIT_ASCEND];
// address freeze overrides the direction bit
wire                        hold   = reg_usrcfg[`SPICFG_BIT_HOLD];
// byte as it stands once the current data bit is shifted in
wire [7:0]                  next_byte = {shreg[6:0], sdi_f};
always @* begin
    case (addr)
        `SPICFG_ADDR_PRIMARY: rdata = reg_primary | (8'h01 << `SPICFG_BIT_OUTPIN);
        `SPICFG_ADDR_DEVCFG:  rdata = reg_devcfg;
        `SPICFG_ADDR_USRCFG:  rdata = reg_usrcfg;
        // unmapped addresses read zero; writes to them are dropped
        default:              rdata = 8'h00;
    endcase
end
////////////////////////////////////////////////////////////////////////////////
// frame sequencer, register writes and the soft reset window
always @(posedge mclk_i or negedge rstn) begin
    if (!rstn) begin
        reg_primary <= `SPICFG_RST_PRIMARY;
        reg_devcfg  <= `SPICFG_RST_DEVCFG;
        reg_usrcfg  <= `SPICFG_RST_USRCFG;
        addr        <= {`SPICFG_ADDR_W{1'b0}};
        bitcnt      <= 5'h00;
        hdr_done    <= 1'b0;
        rd          <= 1'b0;
        shreg       <= 8'h00;
        txreg       <= 8'h00;
        srst_cnt    <= 10'h000;
        srst_busy   <= 1'b0;
        sdo_o       <= 1'b0;
        sdo_oe_o    <= 1'b0;
        chip_rst_o  <= 1'b0;
        pdown_o     <= 1'b0;
        op_mode_o   <= 2'h0;
    end else if (srst_busy) begin
        // whole bank back to defaults
        // link edges are ignored while the window runs, so the host must stay quiet
        reg_primary <= `SPICFG_RST_PRIMARY;
        reg_devcfg  <= `SPICFG_RST_DEVCFG;
        reg_usrcfg  <= `SPICFG_RST_USRCFG;
        hdr_done    <= 1'b0;
        bitcnt      <= 5'h00;
        sdo_oe_o    <= 1'b0;
        pdown_o     <= 1'b0;
        op_mode_o   <= 2'h0;
        // finish inside 750 ns
        // counts down from the load value; zero marks the last cycle of the window
        if (srst_cnt == 10'h000) begin
            srst_busy  <= 1'b0;
            chip_rst_o <= 1'b0;
        end else begin
            srst_cnt <= srst_cnt - 10'h001;
        end
    end else begin
        // mode outputs follow the register one clock later, straight from flops
        op_mode_o <= reg_devcfg[1:0];
        // power down on mode three only
        pdown_o   <= (reg_devcfg[1:0] == `SPICFG_MODE_PDOWN);
        // select high ends the frame and drops any partial byte
        if (csn_new) begin
            bitcnt   <= 5'h00;
            hdr_done <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else if (sclk_rise) begin
            shreg <= next_byte;
            if (!hdr_done) begin
                if (bitcnt == 5'h00)
                    rd <= sdi_f;
                else
                    addr <= {addr[`SPICFG_ADDR_W-2:0], sdi_f};
                if (bitcnt == 5'h0f) begin
                    hdr_done <= 1'b1;
                    bitcnt   <= 5'h00;
                end else begin
                    bitcnt <= bitcnt + 5'h01;
                end
            end else begin
                if (bitcnt == 5'h07) begin
                    bitcnt <= 5'h00;
                    if (!rd) begin
                        if (addr == `SPICFG_ADDR_PRIMARY) begin
                            // the indicator bit is not stored; the read path supplies it
                            reg_primary <= next_byte & ~(8'h01 << `SPICFG_BIT_OUTPIN);
                            if (next_byte[`SPICFG_BIT_SOFTRST]) begin
                                srst_busy  <= 1'b1;
                                chip_rst_o <= 1'b1;
                                srst_cnt   <= SRST_LOAD[9:0];
                            end
                        end
                        if (addr == `SPICFG_ADDR_DEVCFG)
                            reg_devcfg <= next_byte;
                        if (addr == `SPICFG_ADDR_USRCFG)
                            reg_usrcfg <= next_byte;
                    end
                    // steps by the direction held before this byte
                    // freeze address
                    if (!hold) begin
                        if (ascend)
                            addr <= addr + 15'h0001;
                        else
                            addr <= addr - 15'h0001;
                    end
                end else begin
                    bitcnt <= bitcnt + 5'h01;
                end
            end
        end else if (sclk_fall && hdr_done && rd) begin
            // read data only on sdo
            // bits change after the falling edge so the host samples them on the next rise
            sdo_oe_o <= 1'b1;
            // first bit of each byte comes straight from the register, the rest from txreg
            if (bitcnt == 5'h00) begin
                sdo_o <= rdata[7];
                txreg <= {rdata[6:0], 1'b0};
            end else begin
                sdo_o <= txreg[7];
                txreg <= {txreg[6:0], 1'b0};
            end
        end
    end
end
endmodule // spicfg_regs
`default_nettype wire

// file: dv/spicfg_host.sv
// spi host model for the config block
`timescale 1ns/1ns
`default_nettype none
module spicfg_host (
    input  wire logic sdo_i,  // read data
    output var  logic sclk_o, // serial clock
    output var  logic csn_o,  // select, low
    output var  logic sdi_o   // write data
);
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] hdr, input logic [31:0] wd,
                        input int nb, output logic [31:0] rd);
        rd = 32'h0;
        csn_o = 1'b0;
        for (int i = 0; i < 16 + 8 * nb; i++) begin
            sdi_o = (i < 16) ? hdr[15 - i] : wd[47 - i];
            #80 sclk_o = 1'b1;
            if (i >= 16) rd = {rd[30:0], sdo_i};
            #80 sclk_o = 1'b0;
        end
        // gap: sclk idles, sdi not left at a valid level
        #80 csn_o = 1'b1;
        sdi_o = ~sdi_o;
        #160;
    endtask
endmodule // spicfg_host
`default_nettype wire

// file: dv/spicfg_chk_monitor.sv
// assertion checker for the config block
`timescale 1ns/1ns
`default_nettype none
module spicfg_chk (
    input wire logic       mclk_i,     // clock
    input wire logic       rstn_i,     // reset, low
    input wire logic       csn_i,      // select
    input wire logic       sdo_oe_o,   // sdo enable
    input wire logic       chip_rst_o, // soft reset
    input wire logic       pdown_o,    // power down
    input wire logic [1:0] op_mode_o   // mode field
);
    logic [7:0] cnt;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    always_ff @(posedge mclk_i) cnt <= chip_rst_o ? cnt + 8'h01 : 8'h00;
    property p_pdown; $stable(op_mode_o) |-> pdown_o == (op_mode_o == 2'h3); endproperty
    a_pdown: assert property (p_pdown) else $error("pdown wrong");
    property p_rstlen; $fell(chip_rst_o) |-> cnt == 8'h25; endproperty
    a_rstlen: assert property (p_rstlen) else $error("reset length");
    property p_rstcap; chip_rst_o |-> cnt < 8'h25; endproperty
    a_rstcap: assert property (p_rstcap) else $error("reset too long");
    property p_rstclr; chip_rst_o && $past(chip_rst_o) |-> op_mode_o == 2'h0; endproperty
    a_rstclr: assert property (p_rstclr) else $error("mode kept");
    property p_rstquiet; chip_rst_o |-> !sdo_oe_o; endproperty
    a_rstquiet: assert property (p_rstquiet) else $error("sdo in reset");
    property p_oeidle; csn_i [*8] |-> !sdo_oe_o; endproperty
    a_oeidle: assert property (p_oeidle) else $error("sdo idle");
    property p_modeidle; csn_i [*8] |-> $stable(op_mode_o) || chip_rst_o; endproperty
    a_modeidle: assert property (p_modeidle) else $error("mode drift");
    property p_rstsel; $rose(chip_rst_o) |-> $past(csn_i, 2) == 1'b0; endproperty
    a_rstsel: assert property (p_rstsel) else $error("reset no frame");
endmodule // spicfg_chk
bind spicfg_regs spicfg_chk chk_u (.mclk_i, .rstn_i, .csn_i, .sdo_oe_o, .chip_rst_o,
    .pdown_o, .op_mode_o);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the config block
`timescale 1ns/1ns
`default_nettype none
`include "spicfg_consts.vh"
module tb_top;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sclk, csn, sdi, sdo, sdo_oe, chip_rst, pdown;
    logic [1:0] op_mode;
    logic [31:0] rd;
    int err_count = 0;
    int checked = 0;
    int oe_cycles = 0;
    always #10 mclk_i = ~mclk_i;
    // clocks with the read driver enabled; a write frame must add none
    always @(posedge mclk_i)
        if (sdo_oe === 1'b1) oe_cycles <= oe_cycles + 1;
    spicfg_regs dut_u (.mclk_i, .rstn_i, .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .chip_rst_o(chip_rst), .pdown_o(pdown),
        .op_mode_o(op_mode));
    spicfg_host host_u (.sdo_i(sdo), .sclk_o(sclk), .csn_o(csn), .sdi_o(sdi));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [31:0] d, input int nb);
        host_u.xfer({1'b0, a}, d, nb, rd);
    endtask
    task automatic rdx(input logic [14:0] a, input int nb);
        host_u.xfer({1'b1, a}, 32'h0, nb, rd);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_stream();
        int oe0;
        rdx(`SPICFG_ADDR_PRIMARY, 1);
        chk(rd, 32'h30);
        rdx(`SPICFG_ADDR_DEVCFG, 1);
        chk(rd, 32'h00);
        wr(`SPICFG_ADDR_PRIMARY, 32'h0, 1);
        oe0 = oe_cycles;
        rdx(`SPICFG_ADDR_DEVCFG, 3);
        chk(rd, 32'h000010);
        chk(oe_cycles > oe0, 32'h1);
        // direction is set by a byte of its own, since it steers only later bytes
        wr(`SPICFG_ADDR_PRIMARY, 32'h20000000, 1);
        oe0 = oe_cycles;
        wr(`SPICFG_ADDR_PRIMARY, 32'h20ff0300, 3);
        chk(oe_cycles - oe0, 32'h0);
        chk(pdown, 32'h1);
        chk(op_mode, 32'h3);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`SPICFG_ADDR_DEVCFG, m << 24, 1);
            chk(op_mode, m);
            chk(pdown, m == 3);
        end
        wr(`SPICFG_ADDR_USRCFG, 32'h01000000, 1);
        rdx(`SPICFG_ADDR_DEVCFG, 3);
        chk(rd, 32'h030303);
    endtask
    task automatic t_softrst();
        wr(`SPICFG_ADDR_PRIMARY, 32'ha0000000, 1);
        chk(chip_rst, 32'h1);
        // no frame until the reset window is over
        for (int n = 0; n < `SPICFG_SRST_CYC && chip_rst !== 1'b0; n++) @(negedge mclk_i);
        chk(chip_rst, 32'h0);
        chk(op_mode, 32'h0);
        rdx(`SPICFG_ADDR_PRIMARY, 1);
        chk(rd, 32'h30);
        rdx(`SPICFG_ADDR_USRCFG, 1);
        chk(rd, 32'h00);
    endtask
    initial begin
        #1000000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (4) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        t_stream();
        t_modes();
        t_softrst();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
